// ===== core/ffs_pkg.sv
package ffs_pkg;

  // Register bus geometry.
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;

  // Register offsets.
  localparam logic [7:0] BOOST_STATUS_OFS = 8'h10;
  localparam logic [7:0] STRING_STATUS_OFS = 8'h12;
  localparam logic [7:0] BOOST_MASK_OFS = 8'h20;
  localparam logic [7:0] STRING_MASK_OFS = 8'h22;

  // Boost status: fault k has its flag at bit 2k+1 and its clear bit at 2k.
  localparam int unsigned BOOST_FAULTS = 8;
  localparam int unsigned BOOST_OVERTEMP = 7;
  localparam int unsigned BOOST_CURRENT_RES_SHORT = 6;
  localparam int unsigned BOOST_CONFIG_RES_MISSING = 5;
  localparam int unsigned BOOST_MODE_RES_MISSING = 4;
  localparam int unsigned BOOST_FREQ_RES_MISSING = 3;
  localparam int unsigned BOOST_OVERCURRENT = 2;
  localparam int unsigned BOOST_OVERVOLT_HIGH = 1;
  localparam int unsigned BOOST_OVERVOLT_LOW = 0;

  // String status field positions.
  localparam int unsigned STR_RESERVED_BIT = 15;
  localparam int unsigned STR_TIMEOUT_FLAG_BIT = 14;
  localparam int unsigned STR_TIMEOUT_CLEAR_BIT = 13;
  localparam int unsigned STR_BAD_CONFIG_FLAG_BIT = 12;
  localparam int unsigned STR_BAD_CONFIG_CLEAR_BIT = 11;
  localparam int unsigned STR_SUMMARY_FLAG_BIT = 10;
  localparam int unsigned STR_SUMMARY_CLEAR_BIT = 9;
  localparam int unsigned STR_GROUND_SHORT_BIT = 8;
  localparam int unsigned STR_INTERNAL_SHORT_BIT = 7;
  localparam int unsigned STR_OPEN_BIT = 6;
  localparam int unsigned STR_CHANNEL_LSB = 0;
  localparam int unsigned CHANNELS = 6;

  // Interrupt mask layout and reset values.
  localparam logic [15:0] BOOST_MASK_VALID = 16'haaaa;
  localparam logic [15:0] STRING_MASK_VALID = 16'h5400;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

endpackage

// ===== core/ffs_flag_bank.sv
`timescale 1ns/100ps
module ffs_flag_bank #(
  parameter int unsigned N = 8
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Set and clear requests.
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  // Latched flags.
  output logic      [N-1:0] flag_r
);

  logic [N-1:0] flag_nxt;

  initial begin
    if (N < 1) begin
      $error("ffs_flag_bank needs at least one flag");
    end
  end

  // A detector event in the cycle of its clear keeps the flag set.
  assign flag_nxt = set | (flag_r & ~clr);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

// ===== core/ffs_top.sv
`timescale 1ns/100ps
// Operation
// - Clearing needs flag bit and companion clear bit both written one in one write.
// - Boost bit 13 flags current resistor short to ground; bit 12 clears it.
// - Boost bit 11 flags missing configuration resistor; bit 10 clears it.
// - Boost bit 9 flags missing mode resistor; bit 8 clears it.
// - Boost bit 7 flags missing frequency resistor; bit 6 clears it.
// - Boost bit 5 flags boost overcurrent; bit 4 clears it.
// - Boost bit 3 flags boost overvoltage high threshold; bit 2 clears it.
// - Boost bit 1 flags boost overvoltage low threshold; bit 0 clears it.
// - String bit 14 flags bus timeout; bit 13 clears it.
// - String bit 12 flags invalid string configuration; bit 11 clears it.
// - String bit 10 summarises any channel open, short or ground fault; bit 9 clears.
// - String bit 8 is read-only channel ground short flag.
// - String bit 7 is read-only internal short flag, cleared with the summary.
// - String bit 6 is read-only open flag, cleared with the summary.
// - String bits 0 to 5 are read-only fault flags of channels 1 to 6.
// - String bit 15 is reserved and reads zero.
// - Boost bit 15 flags over-temperature shutdown; bit 14 clears it.
module ffs_top #(
  parameter int unsigned CHANNELS = ffs_pkg::CHANNELS
) (
  // Clock and reset.
  input  wire logic                        CLK,
  input  wire logic                        RESET_N,
  // Register port.
  input  wire logic [ffs_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [ffs_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [ffs_pkg::DATA_W-1:0]  RDATA,
  // Boost fault detectors, index as the boost fault numbering.
  input  wire logic [ffs_pkg::BOOST_FAULTS-1:0] BOOST_FAULT_IN,
  // String fault detectors.
  input  wire logic                        STR_TIMEOUT_IN,
  input  wire logic                        STR_BAD_CONFIG_IN,
  input  wire logic [CHANNELS-1:0]         CH_OPEN_IN,
  input  wire logic [CHANNELS-1:0]         CH_SHORT_IN,
  input  wire logic [CHANNELS-1:0]         CH_GROUND_IN,
  // Interrupt.
  output logic                             FAULT_IRQ
);

  localparam int unsigned NB = ffs_pkg::BOOST_FAULTS;
  localparam int unsigned NRAW = NB + 2 + 3 * CHANNELS;
  // Flag bank order: boost faults, timeout, bad config, summary, ground, short, open, channels.
  localparam int unsigned F_TMO = NB;
  localparam int unsigned F_CFG = NB + 1;
  localparam int unsigned F_SUM = NB + 2;
  localparam int unsigned F_GND = NB + 3;
  localparam int unsigned F_SHT = NB + 4;
  localparam int unsigned F_OPN = NB + 5;
  localparam int unsigned F_CH = NB + 6;
  localparam int unsigned NFLAG = F_CH + CHANNELS;

  initial begin
    if (CHANNELS != ffs_pkg::CHANNELS) begin
      $error("ffs_top channel count must match the string status layout");
    end
  end

  // Detector inputs come from outside the clock domain.
  logic [NRAW-1:0] raw;
  logic [NRAW-1:0] sync1_r;
  logic [NRAW-1:0] sync2_r;
  logic [NRAW-1:0] sync3_r;
  logic [NRAW-1:0] det_r;

  assign raw = {CH_GROUND_IN, CH_SHORT_IN, CH_OPEN_IN, STR_BAD_CONFIG_IN, STR_TIMEOUT_IN, BOOST_FAULT_IN};

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A level is taken only once the second and third stages agree, rejecting one-cycle glitches.
  genvar g;
  generate
    for (g = 0; g < NRAW; g++) begin : g_filt
      always_ff @(posedge CLK) begin
        if (!RESET_N) begin
          det_r[g] <= 1'b0;
        end else if (sync2_r[g] == sync3_r[g]) begin
          det_r[g] <= sync3_r[g];
        end
      end
    end
  endgenerate

  logic [NB-1:0]       boost_det;
  logic [CHANNELS-1:0] open_det;
  logic [CHANNELS-1:0] short_det;
  logic [CHANNELS-1:0] gnd_det;

  assign boost_det = det_r[NB-1:0];
  assign open_det = det_r[NB+2 +: CHANNELS];
  assign short_det = det_r[NB+2+CHANNELS +: CHANNELS];
  assign gnd_det = det_r[NB+2+2*CHANNELS +: CHANNELS];

  // Register decode.
  logic wr_boost;
  logic wr_string;
  logic wr_bmask;
  logic wr_smask;

  assign wr_boost = WR && (ADDR == ffs_pkg::BOOST_STATUS_OFS);
  assign wr_string = WR && (ADDR == ffs_pkg::STRING_STATUS_OFS);
  assign wr_bmask = WR && (ADDR == ffs_pkg::BOOST_MASK_OFS);
  assign wr_smask = WR && (ADDR == ffs_pkg::STRING_MASK_OFS);

  // Paired clear: flag bit and its companion clear bit both one in the same write.
  function automatic logic pair_clear(input logic [15:0] d, input int unsigned flag_bit);
    pair_clear = d[flag_bit] & d[flag_bit-1];
  endfunction

  // Set and clear vectors for the flag bank.
  logic [NFLAG-1:0] set_v;
  logic [NFLAG-1:0] clr_v;
  logic             sum_clr;

  assign sum_clr = wr_string && pair_clear(WDATA, ffs_pkg::STR_SUMMARY_FLAG_BIT);

  generate
    for (g = 0; g < NB; g++) begin : g_boost
      assign set_v[g] = boost_det[g];
      assign clr_v[g] = wr_boost && pair_clear(WDATA, 2 * g + 1);
    end
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      assign set_v[F_CH+g] = open_det[g] | short_det[g] | gnd_det[g];
      assign clr_v[F_CH+g] = sum_clr;
    end
  endgenerate

  assign set_v[F_TMO] = det_r[NB];
  assign clr_v[F_TMO] = wr_string && pair_clear(WDATA, ffs_pkg::STR_TIMEOUT_FLAG_BIT);
  assign set_v[F_CFG] = det_r[NB+1];
  assign clr_v[F_CFG] = wr_string && pair_clear(WDATA, ffs_pkg::STR_BAD_CONFIG_FLAG_BIT);
  assign set_v[F_SUM] = |{open_det, short_det, gnd_det};
  assign clr_v[F_SUM] = sum_clr;
  assign set_v[F_GND] = |gnd_det;
  assign clr_v[F_GND] = sum_clr;
  assign set_v[F_SHT] = |short_det;
  assign clr_v[F_SHT] = sum_clr;
  assign set_v[F_OPN] = |open_det;
  assign clr_v[F_OPN] = sum_clr;

  logic [NFLAG-1:0] flag;

  ffs_flag_bank #(
    .N (NFLAG)
  ) u_flags (
    .clk     (CLK),
    .reset_n (RESET_N),
    .set     (set_v),
    .clr     (clr_v),
    .flag_r  (flag)
  );

  // Status read images; clear bits are write-only and read zero.
  logic [15:0] boost_img;
  logic [15:0] string_img;

  always_comb begin
    boost_img = ffs_pkg::STATUS_RESET;
    for (int k = 0; k < NB; k++) begin
      boost_img[2*k+1] = flag[k];
    end
  end

  always_comb begin
    string_img = ffs_pkg::STATUS_RESET;
    string_img[ffs_pkg::STR_RESERVED_BIT] = 1'b0;
    string_img[ffs_pkg::STR_TIMEOUT_FLAG_BIT] = flag[F_TMO];
    string_img[ffs_pkg::STR_BAD_CONFIG_FLAG_BIT] = flag[F_CFG];
    string_img[ffs_pkg::STR_SUMMARY_FLAG_BIT] = flag[F_SUM];
    string_img[ffs_pkg::STR_GROUND_SHORT_BIT] = flag[F_GND];
    string_img[ffs_pkg::STR_INTERNAL_SHORT_BIT] = flag[F_SHT];
    string_img[ffs_pkg::STR_OPEN_BIT] = flag[F_OPN];
    string_img[ffs_pkg::STR_CHANNEL_LSB +: CHANNELS] = flag[F_CH +: CHANNELS];
  end

  // Interrupt masks, same layout as the status registers.
  logic [15:0] bmask_r;
  logic [15:0] smask_r;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      bmask_r <= ffs_pkg::BOOST_MASK_VALID;
      smask_r <= ffs_pkg::STRING_MASK_VALID;
    end else begin
      if (wr_bmask) begin
        bmask_r <= WDATA & ffs_pkg::BOOST_MASK_VALID;
      end
      if (wr_smask) begin
        smask_r <= WDATA & ffs_pkg::STRING_MASK_VALID;
      end
    end
  end

  // Read data stand only in the cycle after the read strobe.
  logic [15:0] rdata_nxt;

  always_comb begin
    rdata_nxt = ffs_pkg::STATUS_RESET;
    if (RD) begin
      case (ADDR)
        ffs_pkg::BOOST_STATUS_OFS:  rdata_nxt = boost_img;
        ffs_pkg::STRING_STATUS_OFS: rdata_nxt = string_img;
        ffs_pkg::BOOST_MASK_OFS:    rdata_nxt = bmask_r;
        ffs_pkg::STRING_MASK_OFS:   rdata_nxt = smask_r;
        default:                    rdata_nxt = ffs_pkg::STATUS_RESET;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      RDATA <= ffs_pkg::STATUS_RESET;
    end else begin
      RDATA <= rdata_nxt;
    end
  end

  // The interrupt follows the flags one cycle late, so a paired clear drops it one edge after the flag clears.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      FAULT_IRQ <= 1'b0;
    end else begin
      FAULT_IRQ <= |((boost_img & bmask_r) | (string_img & smask_r));
    end
  end

endmodule

// ===== sim/ffs_asserts.sv
`timescale 1ns/100ps
module ffs_asserts #(
  parameter int unsigned CHANNELS = ffs_pkg::CHANNELS
) (
  // Clock, reset and register port.
  input wire logic                CLK,
  input wire logic                RESET_N,
  input wire logic [7:0]          ADDR,
  input wire logic [15:0]         WDATA,
  input wire logic                WR,
  input wire logic                RD,
  input wire logic [15:0]         RDATA,
  // Detectors and interrupt.
  input wire logic [7:0]          BOOST_FAULT_IN,
  input wire logic                STR_TIMEOUT_IN,
  input wire logic                STR_BAD_CONFIG_IN,
  input wire logic [CHANNELS-1:0] CH_OPEN_IN,
  input wire logic [CHANNELS-1:0] CH_SHORT_IN,
  input wire logic [CHANNELS-1:0] CH_GROUND_IN,
  input wire logic                FAULT_IRQ
);
  logic [15:0] bmask_r;
  logic [7:0]  recent_r;
  logic        any_in;
  assign any_in = |{BOOST_FAULT_IN, STR_TIMEOUT_IN, STR_BAD_CONFIG_IN, CH_OPEN_IN, CH_SHORT_IN, CH_GROUND_IN};
  // Shadow mask and recent detector activity; the interrupt may only move after a register write or recent detector activity.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      bmask_r <= ffs_pkg::BOOST_MASK_VALID;
      recent_r <= 8'h00;
    end else begin
      recent_r <= {recent_r[6:0], any_in};
      if (WR && ADDR == ffs_pkg::BOOST_MASK_OFS) begin
        bmask_r <= WDATA & ffs_pkg::BOOST_MASK_VALID;
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_clear_bits; $past(RD) && $past(ADDR) == ffs_pkg::BOOST_STATUS_OFS |-> (RDATA & 16'h5555) == 16'h0000; endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("boost clear bit read back as one");
  property p_reserved; $past(RD) && $past(ADDR) == ffs_pkg::STRING_STATUS_OFS |-> !RDATA[15]; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved string bit read as one");
  property p_str_set; STR_TIMEOUT_IN [*6] ##1 (RD && ADDR == ffs_pkg::STRING_STATUS_OFS) |=> RDATA[14]; endproperty
  a_str_set: assert property (p_str_set) else $error("timeout flag missing");
  property p_boost_set; BOOST_FAULT_IN[2] [*6] ##1 (RD && ADDR == ffs_pkg::BOOST_STATUS_OFS) |=> RDATA[5]; endproperty
  a_boost_set: assert property (p_boost_set) else $error("overcurrent flag missing");
  property p_summary; CH_OPEN_IN[0] [*6] ##1 (RD && ADDR == ffs_pkg::STRING_STATUS_OFS) |=> &RDATA[10:0] == 0 && RDATA[10] && RDATA[6] && RDATA[0]; endproperty
  a_summary: assert property (p_summary) else $error("open channel flags missing");
  property p_irq_on; BOOST_FAULT_IN[7] [*7] ##0 (bmask_r[15] && $past(bmask_r[15])) |-> FAULT_IRQ; endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing for overtemp");
  property p_irq_fall; $fell(FAULT_IRQ) |-> $past(WR) || $past(WR, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
  property p_irq_rise; $rose(FAULT_IRQ) |-> (|recent_r) || $past(WR) || $past(WR, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without a cause");
  property p_mask_read; $past(RD) && $past(ADDR) == ffs_pkg::BOOST_MASK_OFS |-> RDATA == $past(bmask_r); endproperty
  a_mask_read: assert property (p_mask_read) else $error("boost mask read mismatch");
endmodule
bind ffs_top ffs_asserts #(.CHANNELS(CHANNELS)) u_asserts (.CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .BOOST_FAULT_IN, .STR_TIMEOUT_IN, .STR_BAD_CONFIG_IN, .CH_OPEN_IN, .CH_SHORT_IN, .CH_GROUND_IN, .FAULT_IRQ);

// ===== sim/fault_status_flags_bench.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module fault_status_flags_bench;
  localparam logic [7:0] bst_a = ffs_pkg::BOOST_STATUS_OFS;
  localparam logic [7:0] str_a = ffs_pkg::STRING_STATUS_OFS;
  localparam logic [7:0] bmsk_a = ffs_pkg::BOOST_MASK_OFS;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        irq;
  logic [27:0] det = 28'h0000000;
  int          fail_count = 0;
  int          comparisons = 0;
  ffs_top DUT (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .BOOST_FAULT_IN(det[7:0]), .STR_TIMEOUT_IN(det[8]), .STR_BAD_CONFIG_IN(det[9]), .CH_OPEN_IN(det[15:10]),
    .CH_SHORT_IN(det[21:16]), .CH_GROUND_IN(det[27:22]), .FAULT_IRQ(irq));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(string nm, logic [7:0] a, logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(nm, exp, rdata)
  endtask
  task automatic irq_chk(string nm, int n, logic exp);
    tick(n);
    #1 `CHK(nm, exp, irq)
  endtask
  // Reads while the detector is still high, then lets it fall long enough for a clear to take.
  task automatic fire(int i, logic [7:0] a, logic [15:0] exp, string nm);
    @(posedge clk);
    det[i] <= 1'b1;
    tick(5);
    rd_chk(nm, a, exp);
    @(posedge clk);
    det[i] <= 1'b0;
    tick(5);
  endtask
  task automatic t_reset;
    rd_chk("boost reset", bst_a, 16'h0000);
    rd_chk("string reset", str_a, 16'h0000);
    rd_chk("boost mask reset", bmsk_a, 16'haaaa);
    rd_chk("string mask reset", ffs_pkg::STRING_MASK_OFS, 16'h5400);
    rd_chk("unmapped", 8'h30, 16'h0000);
  endtask
  task automatic t_boost;
    logic [15:0] flag;
    for (int k = 0; k < 8; k++) begin
      flag = 16'h0002 << (2 * k);
      fire(k, bst_a, flag, "boost flag");
      irq_chk("boost irq", 0, 1'b1);
      wr_reg(bst_a, flag);
      wr_reg(bst_a, flag >> 1);
      rd_chk("boost half pair", bst_a, flag);
      wr_reg(bst_a, flag | (flag >> 1));
      irq_chk("boost irq cleared", 2, 1'b0);
      rd_chk("boost cleared", bst_a, 16'h0000);
    end
  endtask
  task automatic t_string;
    fire(8, str_a, 16'h4000, "timeout flag");
    irq_chk("timeout irq", 0, 1'b1);
    wr_reg(str_a, 16'h6000);
    fire(9, str_a, 16'h1000, "bad config flag");
    wr_reg(str_a, 16'h1800);
    fire(10, str_a, 16'h0441, "open ch1");
    fire(19, str_a, 16'h04c9, "short ch4");
    fire(27, str_a, 16'h05e9, "ground ch6");
    wr_reg(str_a, 16'h85ff);
    rd_chk("read-only write", str_a, 16'h05e9);
    wr_reg(str_a, 16'h0600);
    rd_chk("summary cleared", str_a, 16'h0000);
    irq_chk("string irq cleared", 0, 1'b0);
  endtask
  task automatic t_mask;
    wr_reg(bmsk_a, 16'hffff);
    rd_chk("mask writable bits", bmsk_a, 16'haaaa);
    wr_reg(ffs_pkg::STRING_MASK_OFS, 16'habff);
    rd_chk("string mask cleared", ffs_pkg::STRING_MASK_OFS, 16'h0000);
    wr_reg(ffs_pkg::STRING_MASK_OFS, 16'hffff);
    rd_chk("string mask writable bits", ffs_pkg::STRING_MASK_OFS, 16'h5400);
    wr_reg(bmsk_a, 16'h0000);
    fire(2, bst_a, 16'h0020, "masked flag");
    irq_chk("irq masked", 0, 1'b0);
    wr_reg(bmsk_a, 16'h0020);
    irq_chk("irq unmasked", 2, 1'b1);
    wr_reg(bst_a, 16'h0030);
    irq_chk("irq released", 2, 1'b0);
    wr_reg(bmsk_a, 16'haaaa);
  endtask
  // A paired clear while the detector still reports the fault must not drop the flag.
  task automatic t_set_wins;
    @(posedge clk);
    det[3] <= 1'b1;
    tick(6);
    wr_reg(bst_a, 16'h00c0);
    rd_chk("set beats clear", bst_a, 16'h0080);
    irq_chk("irq held by detector", 0, 1'b1);
    @(posedge clk);
    det[3] <= 1'b0;
    tick(5);
    wr_reg(bst_a, 16'h00c0);
    rd_chk("cleared after detector fell", bst_a, 16'h0000);
    irq_chk("irq released after clear", 0, 1'b0);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    tick(4);
    reset_n <= 1'b1;
    t_reset;
    t_boost;
    t_string;
    t_mask;
    t_set_wins;
    tally_and_finish;
  end
endmodule
